// [rtl/ias_cfg.svh]
`ifndef IAS_CFG_SVH
`define IAS_CFG_SVH

// control byte layout and the only prefix the block answers to
`define IAS_CTRL_PREFIX 4'h6
`define IAS_CTRL_PREFIX_MSB 7
`define IAS_CTRL_PREFIX_LSB 4
`define IAS_CTRL_OE_BIT 3
`define IAS_CTRL_CMD_MSB 2
`define IAS_CTRL_CMD_LSB 0

// command select codes
`define IAS_CMD_WLOCK 3'h0
`define IAS_CMD_READ 3'h1
`define IAS_CMD_WRITE 3'h2
`define IAS_CMD_CLAIM 3'h4
`define IAS_CMD_CLEAR 3'h6

// node identifier value after power-up and after a clear
`define IAS_ID_RESET 8'h00

// bit positions within one nine-clock byte frame
`define IAS_LAST_DATA_BIT 4'h7
`define IAS_ACK_SLOT 4'h8

// index of the last serial-number bit (48 bits, sent msb first)
`define IAS_SER_LAST 6'h2F

`endif

// [rtl/ias_pkg.sv]
package ias_pkg;

	typedef enum logic [8:0] {
		ph_idle = 9'h001, // bus idle or after stop
		ph_ctrl = 9'h002, // receiving control byte
		ph_idb = 9'h004, // receiving identifier byte
		ph_ser = 9'h008, // sending serial number, arbitrating
		ph_wstop = 9'h010, // won claim, waiting for stop
		ph_clr = 9'h020, // receiving the don't-care byte of a clear
		ph_wclr = 9'h040, // clear complete, waiting for stop
		ph_pass = 9'h080, // addressed: data phase handled elsewhere
		ph_ign = 9'h100 // not addressed or lost, silent until start/stop
	} ias_phase_e;

endpackage : ias_pkg

// [rtl/ias_link_rx.sv]
`timescale 1ns/1ps
`default_nettype none

// runs on the link clock: samples the data line on each rising edge and
// flags the new bit with a toggle. the bit stays stable until the next
// rising edge, which is microseconds away, so the system side may read it
// once the toggle has passed its synchroniser.
module ias_link_rx (
	input wire logic scl_clk, // link clock, rising edge samples data
	input wire logic sda_in, // raw data line
	output logic bit_q, // last sampled bit
	output logic tog_q // flips once per sampled bit
);

	// no reset here: the link clock stands still outside frames, so a reset
	// could never be clocked in; only the toggle's changes are meaningful
	logic smp_bit_q = 1'b1;
	logic smp_tog_q = 1'b0;

	always_ff @(posedge scl_clk) begin
		smp_bit_q <= sda_in;
		smp_tog_q <= ~smp_tog_q;
	end

	assign bit_q = smp_bit_q;
	assign tog_q = smp_tog_q;

endmodule : ias_link_rx

`default_nettype wire

// [rtl/ias_id_assign.sv]
// Overview of operation
// - node identifier is volatile, 00 after reset
// - first byte after start is control byte
// - ack only control bytes with prefix 0110
// - decode wlock, read, write, claim, clear codes
// - output-select bit steers external select pin
// - assigned device ignores claim commands
// - claim is control, identifier, 48 serial bits
// - device acks control and identifier bytes
// - drive one, see zero: stop driving
// - other stop aborts claim, no assignment
// - winner loads identifier on stop
// - select pin asserts after identifier-byte ack
// - clear returns identifier to 00
// - other stop aborts clear, line released
// - loser keeps identifier at 00
// - unassigned device executes commands with 00
// - mismatching identifier: ack control byte only
// - matching identifier executes the command
// - after write lock, never ack lock again
// - no acks during programming cycle
// - fixed 48-bit serial number is arbitration value
// - select pin state latched until changed
`timescale 1ns/1ps
`default_nettype none
`include "ias_cfg.svh"

module ias_id_assign #(
	parameter logic [47:0] SERIAL_NUM = 48'h0000_0000_0001 // arbitrary value, set per part
) (
	input wire logic sys_clk, // system clock, 20 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic scl, // link clock pin
	input wire logic sda_in, // data line level
	output logic sda_out, // data line drive value, always low
	output logic sda_oe_n, // data line drive enable, low drives
	output logic eds_out, // select pin drive value, always low
	output logic eds_oe_n, // external_select_pin enable, low pulls pin low
	input wire logic prog_busy, // programming cycle in progress
	input wire logic wlock_done, // write lock already set
	output logic [7:0] node_identifier, // current node identifier
	output logic id_assigned, // an identifier has been claimed
	output logic cmd_go, // one-cycle pulse: addressed command accepted
	output logic [2:0] cmd_code // command_select_field of accepted command
);

	function automatic logic ser_bit_at(input logic [5:0] idx);
		ser_bit_at = SERIAL_NUM[`IAS_SER_LAST - idx];
	endfunction : ser_bit_at

	function automatic logic cmd_known(input logic [2:0] c);
		cmd_known = (c == `IAS_CMD_WLOCK) || (c == `IAS_CMD_READ) || (c == `IAS_CMD_WRITE) ||
			(c == `IAS_CMD_CLAIM) || (c == `IAS_CMD_CLEAR);
	endfunction : cmd_known

	// pin synchronisers; logic reads the second and third stages
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	logic tog_m_q, tog_s_q, tog_p_q;
	logic rx_bit, link_tog;

	ias_link_rx u_link (
		.scl_clk(scl),
		.sda_in(sda_in),
		.bit_q(rx_bit),
		.tog_q(link_tog)
	);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// toggle crossing: tog_p_q is reset to follow the link so no false event
	always_ff @(posedge sys_clk) begin
		tog_m_q <= link_tog;
		tog_s_q <= tog_m_q;
		tog_p_q <= srst ? tog_s_q : tog_p_q ^ (tog_s_q ^ tog_p_q);
	end

	ias_pkg::ias_phase_e phase_q, phase_d;
	logic [3:0] bit_cnt_q;
	logic [7:0] shreg_q;
	logic ack_q;
	logic [2:0] cmd_q;
	logic oe_q;
	logic [7:0] new_id_q;
	logic [5:0] ser_cnt_q;
	logic [7:0] node_id_q;
	logic assigned_q;
	logic eds_pend_q;
	logic sda_oe_n_q, eds_oe_n_q;
	logic cmd_go_q;
	logic [2:0] cmd_code_q;

	// line events seen through the synchronisers
	wire bit_ev = tog_s_q ^ tog_p_q;
	wire scl_fall = scl_p_q & ~scl_s_q;
	wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	wire data_slot = bit_cnt_q != `IAS_ACK_SLOT;
	wire byte_done = bit_ev && (bit_cnt_q == `IAS_LAST_DATA_BIT);
	wire ack_ev = bit_ev && (bit_cnt_q == `IAS_ACK_SLOT);
	wire [7:0] rx_byte = {shreg_q[6:0], rx_bit};

	// control byte fields
	wire [3:0] ctrl_prefix = rx_byte[`IAS_CTRL_PREFIX_MSB:`IAS_CTRL_PREFIX_LSB];
	wire ctrl_oe = rx_byte[`IAS_CTRL_OE_BIT];
	wire [2:0] ctrl_cmd = rx_byte[`IAS_CTRL_CMD_MSB:`IAS_CTRL_CMD_LSB];
	wire ctrl_claim_locked = (ctrl_cmd == `IAS_CMD_CLAIM) && assigned_q;
	wire ctrl_lock_locked = (ctrl_cmd == `IAS_CMD_WLOCK) && wlock_done;
	wire ctrl_ok = (ctrl_prefix == `IAS_CTRL_PREFIX) && cmd_known(ctrl_cmd) &&
		!ctrl_claim_locked && !ctrl_lock_locked && !prog_busy;

	// identifier byte: plain equality also covers 00 while unassigned
	wire id_hit = (rx_byte == node_id_q);
	wire is_claim = (cmd_q == `IAS_CMD_CLAIM);

	// arbitration: releasing for a one while the line reads zero means we lost
	wire my_bit = ser_bit_at(ser_cnt_q);
	wire in_ser = (phase_q == ias_pkg::ph_ser);
	wire lost = bit_ev && in_ser && data_slot && my_bit && !rx_bit;

	wire ack_set = byte_done && (((phase_q == ias_pkg::ph_ctrl) && ctrl_ok) ||
		((phase_q == ias_pkg::ph_idb) &&
		((phase_d == ias_pkg::ph_ser) || (phase_d == ias_pkg::ph_pass))));
	wire drive_low = ((bit_cnt_q == `IAS_ACK_SLOT) && ack_q) ||
		(in_ser && data_slot && !my_bit);
	wire win_stop = stop_det && (phase_q == ias_pkg::ph_wstop);
	wire clr_stop = stop_det && (phase_q == ias_pkg::ph_wclr);
	wire eds_cause = (ack_ev && eds_pend_q) || clr_stop;

	always_comb begin
		phase_d = phase_q;
		if (start_det) begin
			phase_d = ias_pkg::ph_ctrl;
		end else if (stop_det) begin
			phase_d = ias_pkg::ph_idle;
		end else if (scl_fall && (bit_cnt_q != 4'h0) && data_slot &&
			((phase_q == ias_pkg::ph_wstop) || (phase_q == ias_pkg::ph_wclr))) begin
			// a bit finished past the closing ack spoils the ending; the stop's own
			// rising clock is never followed by a fall, so it does not count
			phase_d = ias_pkg::ph_ign;
		end else if (bit_ev) begin
			case (phase_q)
				ias_pkg::ph_ctrl: begin
					if (byte_done) begin
						if (!ctrl_ok) begin
							phase_d = ias_pkg::ph_ign;
						end else if (ctrl_cmd == `IAS_CMD_CLEAR) begin
							phase_d = ias_pkg::ph_clr;
						end else begin
							phase_d = ias_pkg::ph_idb;
						end
					end
				end
				ias_pkg::ph_idb: begin
					if (byte_done) begin
						if (prog_busy) begin
							phase_d = ias_pkg::ph_ign;
						end else if (is_claim) begin
							phase_d = ias_pkg::ph_ser;
						end else if (id_hit) begin
							phase_d = ias_pkg::ph_pass;
						end else begin
							phase_d = ias_pkg::ph_ign;
						end
					end
				end
				ias_pkg::ph_ser: begin
					if (lost) begin
						phase_d = ias_pkg::ph_ign;
					end else if (byte_done && (ser_cnt_q == `IAS_SER_LAST)) begin
						phase_d = ias_pkg::ph_wstop;
					end
				end
				ias_pkg::ph_clr: begin
					if (byte_done) begin
						phase_d = ias_pkg::ph_wclr;
					end
				end
				default: begin
					phase_d = phase_q;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			phase_q <= ias_pkg::ph_idle;
			bit_cnt_q <= 4'h0;
			shreg_q <= 8'h00;
		end else begin
			phase_q <= phase_d;
			if (start_det || stop_det) begin
				bit_cnt_q <= 4'h0;
			end else if (bit_ev) begin
				bit_cnt_q <= data_slot ? bit_cnt_q + 4'h1 : 4'h0;
			end
			if (bit_ev && data_slot) begin
				shreg_q <= rx_byte;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || start_det || stop_det) begin
			ack_q <= 1'b0;
		end else if (byte_done) begin
			ack_q <= ack_set;
		end else if (ack_ev) begin
			ack_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmd_q <= 3'h0;
			oe_q <= 1'b0;
			new_id_q <= `IAS_ID_RESET;
		end else begin
			if (byte_done && (phase_q == ias_pkg::ph_ctrl)) begin
				cmd_q <= ctrl_cmd;
				oe_q <= ctrl_oe;
			end
			if (byte_done && (phase_q == ias_pkg::ph_idb)) begin
				new_id_q <= rx_byte;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || start_det) begin
			ser_cnt_q <= 6'h00;
		end else if (bit_ev && in_ser && data_slot) begin
			ser_cnt_q <= ser_cnt_q + 6'h01;
		end
	end

	// the identifier changes only on a well-placed stop; losers never touch it
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			node_id_q <= `IAS_ID_RESET;
			assigned_q <= 1'b0;
		end else if (win_stop) begin
			node_id_q <= new_id_q;
			assigned_q <= 1'b1;
		end else if (clr_stop) begin
			node_id_q <= `IAS_ID_RESET;
			assigned_q <= 1'b0;
		end
	end

	// select pin follows the output-select bit once the identifier byte is acked,
	// or at the closing stop of a clear, and holds in between
	always_ff @(posedge sys_clk) begin
		if (srst || start_det || stop_det) begin
			eds_pend_q <= 1'b0;
		end else if (byte_done && (phase_q == ias_pkg::ph_idb)) begin
			eds_pend_q <= ack_set;
		end else if (ack_ev) begin
			eds_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			eds_oe_n_q <= 1'b1;
		end else if (eds_cause) begin
			eds_oe_n_q <= ~oe_q;
		end
	end

	// data line changes only after a synchronised falling clock, never while high
	always_ff @(posedge sys_clk) begin
		if (srst || start_det || stop_det) begin
			sda_oe_n_q <= 1'b1;
		end else if (scl_fall) begin
			sda_oe_n_q <= ~drive_low;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cmd_go_q <= 1'b0;
			cmd_code_q <= 3'h0;
		end else begin
			cmd_go_q <= ack_ev && eds_pend_q && (phase_q == ias_pkg::ph_pass);
			if (ack_ev && eds_pend_q) begin
				cmd_code_q <= cmd_q;
			end
		end
	end

	assign sda_out = 1'b0;
	assign eds_out = 1'b0;
	assign sda_oe_n = sda_oe_n_q;
	assign eds_oe_n = eds_oe_n_q;
	assign node_identifier = node_id_q;
	assign id_assigned = assigned_q;
	assign cmd_go = cmd_go_q;
	assign cmd_code = cmd_code_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_ctrl_done;
		byte_done && (phase_q == ias_pkg::ph_ctrl);
	endsequence

	sequence s_idb_done;
		byte_done && (phase_q == ias_pkg::ph_idb);
	endsequence

	sequence s_released;
		sda_oe_n_q && (phase_q == ias_pkg::ph_idle);
	endsequence

	a_id_reset_zero: assert property (@(posedge sys_clk) $fell(srst) |-> node_id_q == `IAS_ID_RESET && !assigned_q)
		else $error("identifier not cleared by reset");

	a_bad_prefix_nack: assert property (s_ctrl_done ##0 (ctrl_prefix != 4'h6) |=> !ack_q && phase_q == ias_pkg::ph_ign)
		else $error("control byte with wrong prefix acknowledged");

	a_claim_when_assigned: assert property (s_ctrl_done ##0 (ctrl_cmd == 3'h4 && assigned_q) |=> !ack_q)
		else $error("assigned device acknowledged a claim");

	a_lock_once_only: assert property (s_ctrl_done ##0 (ctrl_cmd == 3'h0 && wlock_done) |=> !ack_q)
		else $error("write lock acknowledged after lock set");

	a_busy_no_ack: assert property (byte_done && prog_busy |=> !ack_q)
		else $error("acknowledge armed during programming cycle");

	a_id_mismatch_nack: assert property (s_idb_done ##0 (!is_claim && !id_hit) |=> !ack_q ##1 !eds_pend_q)
		else $error("mismatching identifier acknowledged");

	a_ack_drives_low: assert property (ack_q && bit_cnt_q == 4'h8 && scl_fall |=> !sda_oe_n_q)
		else $error("armed acknowledge not driven");

	a_lose_goes_quiet: assert property (lost |=> phase_q == ias_pkg::ph_ign && sda_oe_n_q)
		else $error("device kept arbitrating after losing");

	a_silent_ignore: assert property (phase_q == ias_pkg::ph_ign && scl_fall |=> sda_oe_n_q)
		else $error("ignoring device drove the data line");

	a_win_loads_id: assert property (win_stop |=> node_id_q == $past(new_id_q) && assigned_q ##0 s_released)
		else $error("winning stop did not load identifier");

	a_abort_keeps_id: assert property (stop_det && !win_stop && !clr_stop |=> $stable(node_id_q) ##0 s_released)
		else $error("aborted command changed identifier");

	a_clear_to_zero: assert property (clr_stop |=> node_id_q == 8'h00 && !assigned_q)
		else $error("clear did not return identifier to zero");

	a_eds_latched: assert property ($changed(eds_oe_n_q) |-> $past(eds_cause))
		else $error("select pin changed without a command");

endmodule : ias_id_assign

`default_nettype wire

// [verification/ias_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// bus controller; every line change lands on a falling system-clock edge
module ias_host_model (
	input wire logic sys_clk, // bench system clock
	input wire logic sda, // resolved data line
	output logic scl, // link clock, high between frames
	output logic sda_drv // controller drive, 1 releases the line
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic start();
		sda_drv = 1'b1;
		scl = 1'b1;
		tick(10);
		sda_drv = 1'b0;
		tick(10);
		scl = 1'b0;
		tick(5);
	endtask : start
	task automatic stop();
		sda_drv = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(10);
		sda_drv = 1'b1;
		tick(10);
	endtask : stop
	// data moves mid-low, after the device has had its 2-3 clocks to react
	task automatic bit_x(input logic b, output logic r);
		sda_drv = b;
		tick(5);
		scl = 1'b1;
		tick(10);
		r = sda;
		scl = 1'b0;
		tick(5);
	endtask : bit_x
	// hack set: controller fills the ack slot itself, as a clear ends
	task automatic wr_byte(input logic [7:0] v, input logic hack, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(v[i], r);
		end
		bit_x(~hack, r);
		ack = ~r;
	endtask : wr_byte
	// serial bytes 1-5 are acked, the sixth is not
	task automatic rd_byte(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, v[i]);
		end
		bit_x(last, r);
	endtask : rd_byte
endmodule : ias_host_model

`default_nettype wire

// [verification/i2c_id_assign_addressing_test.sv]
`timescale 1ns/1ps
`default_nettype none

module i2c_id_assign_addressing_test;
	localparam logic [47:0] SER_A = 48'h0000_0000_0001; // arbitrary
	localparam logic [47:0] SER_B = 48'h0000_0000_0002; // arbitrary, loses to SER_A at bit 1
	logic sys_clk, srst, scl, host_sda, sda, prog_busy, wlock_a;
	logic a_out, a_oe_n, a_eds, a_asg, a_go, b_out, b_oe_n, b_eds, b_asg, b_go;
	logic [7:0] a_nid, b_nid;
	logic [2:0] a_code, b_code;
	logic ack_a, ack_b;
	logic a_eo, b_eo;
	int go_a = 0;
	int go_b = 0;
	int error_cnt = 0;
	int n_compared = 0;

	assign sda = host_sda & (a_oe_n | a_out) & (b_oe_n | b_out);

	ias_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(host_sda));
	ias_id_assign #(.SERIAL_NUM(SER_A)) dut (.sys_clk(sys_clk), .srst(srst), .scl(scl), .sda_in(sda),
		.sda_out(a_out), .sda_oe_n(a_oe_n), .eds_out(a_eo), .eds_oe_n(a_eds), .prog_busy(prog_busy),
		.wlock_done(wlock_a), .node_identifier(a_nid), .id_assigned(a_asg), .cmd_go(a_go), .cmd_code(a_code));
	ias_id_assign #(.SERIAL_NUM(SER_B)) dut_b (.sys_clk(sys_clk), .srst(srst), .scl(scl), .sda_in(sda),
		.sda_out(b_out), .sda_oe_n(b_oe_n), .eds_out(b_eo), .eds_oe_n(b_eds), .prog_busy(prog_busy),
		.wlock_done(1'b0), .node_identifier(b_nid), .id_assigned(b_asg), .cmd_go(b_go), .cmd_code(b_code));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// per-device drive at each link rise tells whose ack it was
	always @(posedge scl) begin
		ack_a <= ~a_oe_n;
		ack_b <= ~b_oe_n;
	end
	always @(posedge sys_clk) begin
		if (a_go === 1'b1) go_a <= go_a + 1;
		if (b_go === 1'b1) go_b <= go_b + 1;
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("compared %0d, mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic ids(input logic [17:0] exp);
		check({a_nid, a_asg, b_nid, b_asg}, exp);
	endtask : ids

	task automatic t_refuse();
		logic k;
		host.start();
		host.wr_byte(8'h5C, 1'b0, k);
		check(k, 1'b0);
		for (int c = 3; c < 8; c += 2) begin
			host.start();
			host.wr_byte({4'h6, 1'b0, 3'(c)}, 1'b0, k);
			check(k, 1'b0);
		end
		host.stop();
		$display("refuse test done");
	endtask : t_refuse

	task automatic claim(input logic [7:0] id, input logic oe, input logic [1:0] want,
		input logic [1:0] external_select_pin, input logic [47:0] ser);
		logic k;
		logic [7:0] b;
		logic [47:0] s;
		host.start();
		host.wr_byte({4'h6, oe, 3'h4}, 1'b0, k);
		check({ack_a, ack_b}, want);
		host.wr_byte(id, 1'b0, k);
		check({ack_a, ack_b}, want);
		check({a_eds, b_eds}, external_select_pin);
		for (int i = 0; i < 6; i++) begin
			host.rd_byte(i == 5, b);
			s = {s[39:0], b};
		end
		check(s, ser);
		host.stop();
		host.tick(3);
	endtask : claim

	task automatic access(input logic [7:0] ctrl, input logic [7:0] id, input logic [1:0] cw, input logic [1:0] iw);
		logic k;
		int ga;
		int gb;
		ga = go_a;
		gb = go_b;
		host.start();
		host.wr_byte(ctrl, 1'b0, k);
		check({ack_a, ack_b}, cw);
		host.wr_byte(id, 1'b0, k);
		check({ack_a, ack_b}, iw);
		host.stop();
		check({8'(go_a - ga), 8'(go_b - gb)}, {7'h00, iw[1], 7'h00, iw[0]});
		if (iw[1]) check(a_code, ctrl[2:0]);
	endtask : access

	task automatic t_clear();
		logic k;
		logic [7:0] b;
		host.start();
		host.wr_byte(8'h6E, 1'b0, k);
		for (int i = 0; i < 4; i++) host.bit_x(1'b0, k);
		host.stop();
		ids({8'h3A, 1'b1, 8'h5B, 1'b1});
		check(sda, 1'b1);
		host.start();
		host.wr_byte(8'h6E, 1'b0, k);
		host.wr_byte(8'hA5, 1'b1, k);
		host.stop();
		host.tick(3);
		ids({8'h00, 1'b0, 8'h00, 1'b0});
		check({a_eds, b_eds}, 2'b00);
		host.start();
		host.wr_byte(8'h64, 1'b0, k);
		host.wr_byte(8'h77, 1'b0, k);
		// stop one bit short of the end, where every device has let the line go
		for (int i = 0; i < 5; i++) host.rd_byte(1'b0, b);
		for (int i = 0; i < 7; i++) host.bit_x(1'b1, k);
		host.stop();
		ids({8'h00, 1'b0, 8'h00, 1'b0});
		check({sda, a_eds, b_eds}, 3'b111);
		access(8'h61, 8'h00, 2'b11, 2'b11);
		$display("clear test done");
	endtask : t_clear

	initial begin
		// the tests need roughly 9k system clocks; allow about twice that
		#1_000_000;
		error_cnt++;
		conclude();
	end

	initial begin
		srst = 1'b1;
		prog_busy = 1'b0;
		wlock_a = 1'b0;
		repeat (5) @(posedge sys_clk);
		@(negedge sys_clk) srst = 1'b0;
		host.tick(6);
		ids({8'h00, 1'b0, 8'h00, 1'b0});
		check({a_eds, b_eds}, 2'b11);
		check({a_eo, b_eo}, 2'b00);
		t_refuse();
		claim(8'h3A, 1'b1, 2'b11, 2'b00, SER_A);
		ids({8'h3A, 1'b1, 8'h00, 1'b0});
		claim(8'h5B, 1'b0, 2'b01, 2'b01, SER_B);
		ids({8'h3A, 1'b1, 8'h5B, 1'b1});
		$display("claim test done");
		access(8'h69, 8'h3A, 2'b11, 2'b10);
		access(8'h6A, 8'h00, 2'b11, 2'b00);
		access(8'h60, 8'h5B, 2'b11, 2'b01);
		wlock_a = 1'b1;
		access(8'h60, 8'h3A, 2'b01, 2'b00);
		prog_busy = 1'b1;
		access(8'h69, 8'h3A, 2'b00, 2'b00);
		prog_busy = 1'b0;
		$display("access test done");
		t_clear();
		conclude();
	end
endmodule : i2c_id_assign_addressing_test

`default_nettype wire
